// file: tya_pkg.sv
// Shared constants, types and decode helpers for the yellow alarm block.
// Assumes one transmit framer clock and a framer that marks frame edges.
package tya_pkg;

    // Register map
    localparam logic [11:0] CTRL_OFFSET = 12'h108;
    localparam logic [11:0] STAT_OFFSET = 12'h109;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Control field positions
    localparam int RULE_BIT = 7;
    localparam int START_BIT = 6;
    localparam int FMT_MSB = 5;
    localparam int FMT_LSB = 4;

    // Status field positions
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_GAP_BIT = 1;
    localparam int STAT_PULSE_BIT = 2;

    // Format field codes
    localparam logic [1:0] FMT_OFF = 2'h0;
    localparam logic [1:0] FMT_A = 2'h1;
    localparam logic [1:0] FMT_B = 2'h2;
    localparam logic [1:0] FMT_C = 2'h3;

    // Data link patterns and repeat count
    localparam logic [15:0] PAT_HALF = 16'hFF00;
    localparam logic [15:0] PAT_ONES = 16'hFFFF;
    localparam logic [7:0] PAT_REPEATS = 8'hFF;

    // One second measured in frames
    localparam int ONE_SEC_US = 1000000;
    localparam int FRAME_US = 125;
    localparam int FRAMES_PER_SEC = ONE_SEC_US / FRAME_US;

    // Framing select codes from the framer
    localparam logic [2:0] FS_SF = 3'h5;
    localparam logic [2:0] FS_N = 3'h6;
    localparam logic [2:0] FS_DMUX = 3'h7;

    typedef enum logic [2:0] {FR_ESF, FR_SF, FR_N, FR_DMUX, FR_OTHER} tya_framing_t;

    typedef struct packed {
        logic rule_enf;
        logic rai_start_stop_ctl;
        logic [1:0] fmt;
    } tya_ctrl_t;

    typedef struct packed {
        logic bit2_zero;
        logic fs12_one;
        logic y_bit_zero;
        logic dl_rai;
        logic dl_bit;
    } tya_line_t;

    // Framing select to framing kind
    function automatic tya_framing_t decode_framing(input logic [2:0] sel);
        tya_framing_t f;
        f = FR_OTHER;
        if (!sel[2])
            f = FR_ESF;
        else if (sel == FS_SF)
            f = FR_SF;
        else if (sel == FS_N)
            f = FR_N;
        else if (sel == FS_DMUX)
            f = FR_DMUX;
        return f;
    endfunction : decode_framing

endpackage : tya_pkg

// file: tya_sec_timer.sv
// One-second timer counted in transmitted frames.
// Assumes frame_tick is a one-cycle pulse per frame on the same clock.
`timescale 1ns/100ps
module tya_sec_timer #(
    parameter int FRAMES = tya_pkg::FRAMES_PER_SEC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic frame_tick,
    output logic expired
);
    localparam int CNT_W = $clog2(FRAMES + 1);

    logic [CNT_W-1:0] count_q;
    logic expired_q;

    if (FRAMES < 2)
    begin : g_bad_frames
        $error("tya_sec_timer: FRAMES must be at least 2");
    end

    // Expire on the tick after FRAMES ticks, so a partial first frame never shortens it
    always_ff @(posedge sys_clk)
    begin
        if (rst || restart)
        begin
            count_q <= '0;
            expired_q <= 1'b0;
        end
        else if (frame_tick && !expired_q)
        begin
            if (count_q == CNT_W'(FRAMES))
                expired_q <= 1'b1;
            else
                count_q <= count_q + 1'b1;
        end
    end

    assign expired = expired_q;

endmodule : tya_sec_timer

// file: tya_dl_pattern.sv
// Repeating 16-bit yellow alarm pattern for the ESF data link.
// Assumes dl_slot pulses once per data link bit, on the same clock.
`timescale 1ns/100ps
module tya_dl_pattern (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic enable,
    input wire logic dl_slot,
    input wire logic all_ones,
    output logic dl_bit,
    output logic reps_done
);
    logic [3:0] idx_q;
    logic [7:0] reps_q;
    logic dl_bit_q;
    logic [15:0] pat;

    // Pattern choice; sent most significant bit first
    assign pat = all_ones ? tya_pkg::PAT_ONES : tya_pkg::PAT_HALF;

    // Bit index and saturating repetition count
    always_ff @(posedge sys_clk)
    begin
        if (rst || restart || !enable)
        begin
            idx_q <= 4'h0;
            reps_q <= 8'h00;
            dl_bit_q <= 1'b0;
        end
        else if (dl_slot)
        begin
            dl_bit_q <= pat[4'hF - idx_q];
            idx_q <= idx_q + 4'h1;
            if (idx_q == 4'hF && reps_q != tya_pkg::PAT_REPEATS)
                reps_q <= reps_q + 8'h01;
        end
    end

    assign dl_bit = dl_bit_q;
    assign reps_done = (reps_q == tya_pkg::PAT_REPEATS);

endmodule : tya_dl_pattern

// file: tya_yellow_alarm.sv
// Transmit yellow alarm (RAI) generator for one T1 channel.
// Assumes framer timing pulses and framing select on sys_clk.
`timescale 1ns/100ps
module tya_yellow_alarm #(
    parameter int ADDR_W = 12,
    parameter int FRAMES_PER_SEC = tya_pkg::FRAMES_PER_SEC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [2:0] framing_sel,
    input wire logic frame_tick,
    input wire logic dl_slot,
    output tya_pkg::tya_line_t line_ctl,
    output logic rai_active
);

    // Elaboration checks
    if (ADDR_W < 12)
    begin : g_bad_addr
        $error("tya_yellow_alarm: ADDR_W too narrow for the register map");
    end

    if (FRAMES_PER_SEC < 2)
    begin : g_bad_frames
        $error("tya_yellow_alarm: FRAMES_PER_SEC must be at least 2");
    end

    // Episode states:
    // idle waits for a request, min holds the alarm for the first second,
    // hold keeps it while the request stands, gap enforces the spacing.
    // Format zero leaves min and hold at once, so the minimum length
    // is traded away for a clean software abort.
    // The gap is only ever entered with the rule enforced.
    // Leaving the rule mid-gap releases the spacing in one cycle.
    typedef enum logic [1:0] {ST_IDLE, ST_MIN, ST_HOLD, ST_GAP} tya_state_t;

    // Registers, plus the sequencer's next state and timer restart
    tya_pkg::tya_ctrl_t ctrl_q;
    logic [7:0] rdata_q;
    logic fmt0_prev_q;
    logic pulse_run_q;
    tya_state_t state_q;
    tya_state_t state_d;
    logic timer_restart;
    logic bit2_zero_q;
    logic fs12_one_q;
    logic y_bit_zero_q;
    logic dl_rai_q;

    // Wires
    tya_pkg::tya_framing_t framing;
    logic is_esf;
    logic is_sfn;
    logic is_dmux;
    logic fmt_on;
    logic fmt_a_or_c;
    logic fmt_b;
    logic yel0_rise;
    logic req_free;
    logic req_enf;
    logic req;
    logic active;
    logic sec_expired;
    logic dl_bit;
    logic reps_done;
    logic pat_restart;
    logic pat_enable;
    logic ctrl_hit;
    logic stat_hit;
    logic [7:0] ctrl_byte;
    logic [7:0] stat_byte;
    logic [7:0] rd_mux;
    logic in_min;
    logic in_hold;
    logic in_gap;
    logic fmt_c;
    logic ctrl_wr;
    logic wr_rule;
    logic wr_start;
    logic [1:0] wr_fmt;
    logic bit2_zero_d;
    logic fs12_one_d;
    logic y_bit_zero_d;
    logic dl_rai_d;

    // Register decode; full-width compare so aliases never hit
    assign ctrl_hit = (reg_addr == ADDR_W'(tya_pkg::CTRL_OFFSET));
    assign stat_hit = (reg_addr == ADDR_W'(tya_pkg::STAT_OFFSET));

    // Write strobe qualified by the control address
    assign ctrl_wr = reg_wr && ctrl_hit;
    // Incoming control fields, picked by their named positions
    assign wr_rule = reg_wdata[tya_pkg::RULE_BIT];
    assign wr_start = reg_wdata[tya_pkg::START_BIT];
    assign wr_fmt = reg_wdata[tya_pkg::FMT_MSB:tya_pkg::FMT_LSB];

    // Control byte; low nibble is reserved and reads zero
    assign ctrl_byte = {ctrl_q.rule_enf, ctrl_q.rai_start_stop_ctl, ctrl_q.fmt, 4'h0};

    // Status byte shows the generator's own state
    assign stat_byte = {5'h00, pulse_run_q, in_gap, active};

    // Read selection; unmapped addresses read zero
    assign rd_mux = ctrl_hit ? ctrl_byte : (stat_hit ? stat_byte : 8'h00);

    // Control register; status is read-only, writes there are dropped
    // The bus never waits: a write lands on the strobe edge, and the
    // new controls act from the following cycle on.
    // Only the upper nibble is stored; the reserved bits cost no flops.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl_q <= tya_pkg::tya_ctrl_t'(tya_pkg::CTRL_RESET[7:4]);
        end
        else if (ctrl_wr)
        begin
            ctrl_q.rule_enf <= wr_rule;
            ctrl_q.rai_start_stop_ctl <= wr_start;
            ctrl_q.fmt <= wr_fmt;
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            rdata_q <= 8'h00;
        else if (reg_rd)
            rdata_q <= rd_mux;
        else
            rdata_q <= 8'h00;
    end

    assign reg_rdata = rdata_q;

    // Framing kind; other framings get no alarm encoding here
    assign framing = tya_pkg::decode_framing(framing_sel);
    assign is_esf = (framing == tya_pkg::FR_ESF);
    assign is_sfn = (framing == tya_pkg::FR_SF) || (framing == tya_pkg::FR_N);
    assign is_dmux = (framing == tya_pkg::FR_DMUX);

    // Format decode
    assign fmt_on = (ctrl_q.fmt != tya_pkg::FMT_OFF);
    assign fmt_b = (ctrl_q.fmt == tya_pkg::FMT_B);
    assign fmt_a_or_c = fmt_on && !fmt_b;
    assign fmt_c = (ctrl_q.fmt == tya_pkg::FMT_C);

    // A fresh pulse is a low-to-high change of the low format bit
    assign yel0_rise = ctrl_q.fmt[0] && !fmt0_prev_q;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            fmt0_prev_q <= 1'b0;
        else
            fmt0_prev_q <= ctrl_q.fmt[0];
    end

    // Short-pulse flag stays set until 255 patterns have gone out or the format goes to zero
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            pulse_run_q <= 1'b0;
        else if (yel0_rise)
            pulse_run_q <= 1'b1;
        else if (reps_done || !fmt_on)
            pulse_run_q <= 1'b0;
    end

    // Free-running request: format alone sets duration
    // ESF with 10 lasts as long as the upper bit; 01/11 last as long as the low bit is set
    assign req_free = fmt_on && (!is_esf || fmt_b || ctrl_q.fmt[0] || pulse_run_q);

    // Enforced request: start bit governs duration
    assign req_enf = ctrl_q.rai_start_stop_ctl && fmt_on;

    // Start bit only matters with the rule enforced
    assign req = ctrl_q.rule_enf ? req_enf : req_free;

    // Episode sequencer
    // The gap state is entered only when the rule is enforced
    always_comb
    begin
        state_d = state_q;
        timer_restart = 1'b0;
        unique case (state_q)
            ST_IDLE:
            begin
                if (req)
                begin
                    state_d = ST_MIN;
                    timer_restart = 1'b1;
                end
            end
            ST_MIN:
            begin
                // Hold at least one second in every framing unless format zero aborts
                if (!fmt_on)
                    state_d = ST_IDLE;
                else if (sec_expired)
                begin
                    if (req)
                        state_d = ST_HOLD;
                    else if (ctrl_q.rule_enf)
                    begin
                        state_d = ST_GAP;
                        timer_restart = 1'b1;
                    end
                    else
                        state_d = ST_IDLE;
                end
            end
            ST_HOLD:
            begin
                if (!fmt_on)
                    state_d = ST_IDLE;
                else if (!req)
                begin
                    if (ctrl_q.rule_enf)
                    begin
                        state_d = ST_GAP;
                        timer_restart = 1'b1;
                    end
                    else
                        state_d = ST_IDLE;
                end
            end
            ST_GAP:
            begin
                // Dropping the rule mid-gap releases the spacing at once
                if (sec_expired || !ctrl_q.rule_enf)
                    state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // State decode shared by status, alarm level and line encoding
    assign in_min = (state_q == ST_MIN);
    assign in_hold = (state_q == ST_HOLD);
    assign in_gap = (state_q == ST_GAP);

    // Alarm on the line; format zero always silences it
    assign active = fmt_on && (in_min || in_hold);

    // Second counted in transmitted frames
    // Counting frames rather than clocks keeps the second exact whatever
    // the system clock rate, at the cost of needing the framer's tick.
    tya_sec_timer #(
        .FRAMES(FRAMES_PER_SEC)
    ) u_sec_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .restart(timer_restart),
        .frame_tick(frame_tick),
        .expired(sec_expired)
    );

    // ESF pattern restarts on each new pulse and each new episode
    assign pat_restart = yel0_rise || timer_restart;
    assign pat_enable = active && is_esf;

    tya_dl_pattern u_dl_pattern (
        .sys_clk(sys_clk),
        .rst(rst),
        .restart(pat_restart),
        .enable(pat_enable),
        .dl_slot(dl_slot),
        .all_ones(fmt_c),
        .dl_bit(dl_bit),
        .reps_done(reps_done)
    );

    // Next line flags; only the encoding differs between formats
    assign bit2_zero_d = active && is_sfn && fmt_a_or_c;
    assign fs12_one_d = active && is_sfn && fmt_b;
    assign y_bit_zero_d = active && is_dmux;
    assign dl_rai_d = pat_enable;

    // Line encoding, registered so the framer sees clean levels
    // Enforced or not, the format field only chooses which bits change
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            bit2_zero_q <= 1'b0;
            fs12_one_q <= 1'b0;
            y_bit_zero_q <= 1'b0;
            dl_rai_q <= 1'b0;
        end
        else
        begin
            bit2_zero_q <= bit2_zero_d;
            fs12_one_q <= fs12_one_d;
            y_bit_zero_q <= y_bit_zero_d;
            dl_rai_q <= dl_rai_d;
        end
    end

    // Outputs
    assign line_ctl.bit2_zero = bit2_zero_q;
    assign line_ctl.fs12_one = fs12_one_q;
    assign line_ctl.y_bit_zero = y_bit_zero_q;
    assign line_ctl.dl_rai = dl_rai_q;
    assign line_ctl.dl_bit = dl_bit;
    assign rai_active = active;

endmodule : tya_yellow_alarm

// file: tya_yellow_alarm_properties.sv
// Port checker for the yellow alarm generator.
// Assumes it is bound onto tya_yellow_alarm; shadows ctrl from the bus.
`timescale 1ns/100ps
module tya_properties #(
    parameter int ADDR_W = 12,
    parameter int FRAMES_PER_SEC = tya_pkg::FRAMES_PER_SEC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [2:0] framing_sel,
    input wire logic frame_tick,
    input wire tya_pkg::tya_line_t line_ctl,
    input wire logic rai_active
);
    logic [7:0] ctl_q;
    logic [15:0] act_q;
    logic [15:0] gap_q;
    logic arm_q;
    wire [1:0] fmt_w = ctl_q[5:4];
    wire sf_w = framing_sel == tya_pkg::FS_SF;
    // Shadow ctrl, ticks per episode and per gap
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctl_q <= 8'h00;
            act_q <= 16'h0000;
            gap_q <= 16'h0000;
            arm_q <= 1'b0;
        end
        else
        begin
            if (reg_wr && reg_addr == tya_pkg::CTRL_OFFSET)
                ctl_q <= reg_wdata & 8'hF0;
            act_q <= rai_active ? act_q + 16'(frame_tick) : 16'h0000;
            gap_q <= rai_active ? 16'h0000 : gap_q + 16'(frame_tick);
            // Abort by format 00 leaves no gap to honour
            arm_q <= ctl_q[7] && !rai_active && (arm_q || ($fell(rai_active) && fmt_w != 2'h0));
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> !rai_active && line_ctl == '0)
        else $error("outputs not quiet after reset");
    a_read_ctrl: assert property (reg_rd && reg_addr == tya_pkg::CTRL_OFFSET |=> reg_rdata == {$past(ctl_q[7:4]), 4'h0})
        else $error("ctrl read back wrong");
    a_min_len: assert property ($fell(rai_active) && fmt_w != 2'h0 |-> act_q > FRAMES_PER_SEC)
        else $error("alarm shorter than one second");
    a_gap_len: assert property ($rose(rai_active) && arm_q |-> gap_q > FRAMES_PER_SEC)
        else $error("alarm gap shorter than one second");
    a_stop_hold: assert property (ctl_q[7] && !ctl_q[6] && !rai_active |=> !rai_active)
        else $error("alarm began with start clear");
    a_fmt_off: assert property (fmt_w == 2'h0 |-> !rai_active)
        else $error("alarm active with format off");
    a_off_clear: assert property (!rai_active |=> line_ctl == '0)
        else $error("line flags set while idle");
    a_bit2_sf: assert property (rai_active && !ctl_q[7] && fmt_w == 2'h1 && sf_w |=> line_ctl.bit2_zero)
        else $error("bit two not forced");
    a_y_dmux: assert property (rai_active && framing_sel == tya_pkg::FS_DMUX |=> line_ctl.y_bit_zero)
        else $error("Y bit not driven low");
    a_fs12_sf: assert property (rai_active && fmt_w == 2'h2 && sf_w |=> line_ctl.fs12_one)
        else $error("frame twelve Fs not set");
endmodule : tya_properties

bind tya_yellow_alarm tya_properties #(.ADDR_W(ADDR_W), .FRAMES_PER_SEC(FRAMES_PER_SEC)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .framing_sel(framing_sel),
    .frame_tick(frame_tick), .line_ctl(line_ctl), .rai_active(rai_active));

// file: tya_framer_model.sv
// Framer timing model: frame pulses and data link slots.
// Assumes the bench supplies clock and reset; quiet in reset.
`timescale 1ns/100ps
module tya_framer_model #(
    parameter int FRAME_CYC = 16,
    parameter int SLOT_CYC = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    output logic frame_tick,
    output logic dl_slot
);
    int cnt_q;
    // Slots never coincide with ticks, so counts stay unambiguous
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cnt_q <= 0;
            frame_tick <= 1'b0;
            dl_slot <= 1'b0;
        end
        else
        begin
            cnt_q <= (cnt_q == FRAME_CYC - 1) ? 0 : cnt_q + 1;
            frame_tick <= cnt_q == FRAME_CYC - 1;
            dl_slot <= cnt_q % SLOT_CYC == 1;
        end
    end
endmodule : tya_framer_model

// file: tya_yellow_alarm_tb.sv
// Self-checking bench for the yellow alarm generator.
// Assumes the framer model paces frames; one second is F frames here.
`timescale 1ns/100ps
module tya_yellow_alarm_tb;
    localparam int F = 4;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [2:0] framing_sel = 3'h5;
    logic frame_tick;
    logic dl_slot;
    tya_pkg::tya_line_t line_ctl;
    logic rai_active;
    logic [7:0] d;
    logic [15:0] p;
    int n_mismatch = 0;
    int n_compared = 0;
    int act_n = 0;
    int idle_n = 0;
    logic was_act = 1'b0;
    // Rows: ctrl, framing, expected {bit2, fs12, y, dl}
    logic [14:0] rows [13] = '{
        {8'h10, 3'h5, 4'h8}, {8'h50, 3'h5, 4'h8}, {8'h10, 3'h6, 4'h8},
        {8'h10, 3'h7, 4'h2}, {8'h20, 3'h7, 4'h2}, {8'h20, 3'h5, 4'h4},
        {8'h30, 3'h5, 4'h8}, {8'h10, 3'h0, 4'h1}, {8'h20, 3'h0, 4'h1},
        {8'h30, 3'h0, 4'h1}, {8'h90, 3'h5, 4'h0}, {8'hC0, 3'h5, 4'h0},
        {8'hE0, 3'h5, 4'h4}};
    tya_yellow_alarm #(.FRAMES_PER_SEC(F)) u_dut (.sys_clk(sys_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .framing_sel(framing_sel), .frame_tick(frame_tick),
        .dl_slot(dl_slot), .line_ctl(line_ctl), .rai_active(rai_active));
    tya_framer_model u_frm (.sys_clk(sys_clk), .rst(rst), .frame_tick(frame_tick),
        .dl_slot(dl_slot));
    initial
    begin
        forever #2 sys_clk = ~sys_clk;
    end
    // Ticks per episode and per idle spell; each holds until its phase restarts
    always @(posedge sys_clk)
    begin
        was_act <= rai_active;
        if (rai_active)
            act_n <= (was_act ? act_n : 0) + frame_tick;
        else
            idle_n <= (was_act ? 0 : idle_n) + frame_tick;
    end
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Extra edge after the strobe so no re-entry lands in one step
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [7:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge sys_clk);
    endtask : rd
    task automatic wait_act(input logic v);
        for (int i = 0; i < 4000 && rai_active !== v; i++)
            @(posedge sys_clk);
        #1;
        if (rai_active !== v)
        begin
            n_mismatch++;
            test_done();
        end
    endtask : wait_act
    // Data link bits, each one cycle after its slot
    task automatic grab();
        int k;
        k = 0;
        for (int i = 0; i < 400 && k < 16; i++)
        begin
            @(posedge sys_clk);
            #1;
            if (dl_slot === 1'b1)
            begin
                @(posedge sys_clk);
                #1 p = {p[14:0], line_ctl.dl_bit};
                k++;
            end
        end
        if (k < 16)
        begin
            n_mismatch++;
            test_done();
        end
    endtask : grab
    initial
    begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        foreach (rows[i])
        begin
            framing_sel <= rows[i][6:4];
            wr(tya_pkg::CTRL_OFFSET, rows[i][14:7]);
            repeat (4) @(posedge sys_clk);
            #1;
            chk("line", 16'(line_ctl[4:1]), 16'(rows[i][3:0]));
            chk("active", 16'(rai_active), 16'(|rows[i][3:0]));
            wr(tya_pkg::CTRL_OFFSET, 8'h00);
            repeat (2) @(posedge sys_clk);
            #1;
            chk("off", 16'({line_ctl, rai_active}), 16'h0000);
        end
        rst <= 1'b1;
        @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        wr(tya_pkg::CTRL_OFFSET, 8'h0F);
        rd(tya_pkg::CTRL_OFFSET, d);
        chk("ctrl", 16'(d), 16'h0000);
        rd(12'h10A, d);
        chk("unmapped", 16'(d), 16'h0000);
        framing_sel <= tya_pkg::FS_N;
        wr(tya_pkg::CTRL_OFFSET, 8'hF0);
        rd(tya_pkg::CTRL_OFFSET, d);
        chk("ctrl", 16'(d), 16'h00F0);
        wr(tya_pkg::CTRL_OFFSET, 8'h00);
        framing_sel <= 3'h0;
        wr(tya_pkg::CTRL_OFFSET, 8'h30);
        grab();
        chk("ones", p, tya_pkg::PAT_ONES);
        wr(tya_pkg::CTRL_OFFSET, 8'h00);
        wr(tya_pkg::CTRL_OFFSET, 8'h10);
        grab();
        chk("half", 16'($countones(p)), 16'h0008);
        chk("edges", 16'($countones(p ^ {p[14:0], p[15]})), 16'h0002);
        framing_sel <= tya_pkg::FS_SF;
        wr(tya_pkg::CTRL_OFFSET, 8'h00);
        wr(tya_pkg::CTRL_OFFSET, 8'hD0);
        wr(tya_pkg::CTRL_OFFSET, 8'h90);
        wait_act(1'b0);
        chk("min", 16'(act_n), 16'(F + 1));
        wr(tya_pkg::CTRL_OFFSET, 8'hD0);
        wait_act(1'b1);
        chk("gap", 16'(idle_n), 16'(F + 1));
        wr(tya_pkg::CTRL_OFFSET, 8'h00);
        chk("abort", 16'(rai_active), 16'h0000);
        wr(tya_pkg::CTRL_OFFSET, 8'h10);
        wait_act(1'b1);
        chk("nogap", 16'(idle_n <= 1), 16'h0001);
        test_done();
    end
endmodule : tya_yellow_alarm_tb
